// ---- core/dpl_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Two select lines pick one of four presets
// - Preset scales span or external sum
// - Type 0 sum, 1 relative, 2 switch
// - Current ceiling 0.1 to 1.1 rated
// - Keypad stop at ceiling: coast immediately
// - Skip band around bypass; zero disables
// - Four bypass frequencies, clamped, default 120
// - Low current: warn or trip per action
// - High current raises warning
// - Low frequency warning, default limit zero
// - High frequency warning, 120/1000 Hz range
// - Low reference warning, default range bottom
// - Warnings suppressed ramping or stopped
// - Warnings enabled once reference reached
// - Warnings routable to outputs and relays
// - Reference limits only under remote reference
// - Low current limit within zero to high
// - Reference unit Hz open, process closed
module dpl_monitor
    import dpl_pkg::*;
#(
    parameter logic [15:0] RATED_CURRENT = 16'h0064,  // 10.0 A
    parameter logic [15:0] MAX_CURRENT = 16'h0096     // 15.0 A
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // AXI4-Lite write
    input wire logic [dpl_pkg::DPL_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [dpl_pkg::DPL_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pins and drive state
    input wire logic presetSelHi,
    input wire logic presetSelLo,
    input wire logic extPresetSel,
    input wire logic localKeypadStop,
    input wire logic remoteRefActive,
    input wire logic closedLoop,
    input wire logic rampingUp,
    input wire logic rampingDown,
    input wire logic stopped,
    input wire logic [dpl_pkg::DPL_CURR_W-1:0] motorCurrent,
    input wire logic [dpl_pkg::DPL_FREQ_W-1:0] outputFreq,
    input wire logic [dpl_pkg::DPL_FREQ_W-1:0] freqDemand,
    input wire logic [dpl_pkg::DPL_REF_W-1:0] extRefSum,
    input wire logic [dpl_pkg::DPL_REF_W-1:0] remoteRef,
    // Results
    output logic [dpl_pkg::DPL_REF_W-1:0] resultRef,
    output logic [dpl_pkg::DPL_FREQ_W-1:0] freqCommand,
    output logic [dpl_pkg::DPL_CURR_W-1:0] currentCeiling,
    output logic outputOff,
    output logic noLoadTrip,
    output logic [5:0] warnFlags,
    output logic [1:0] signalOut,
    output logic [1:0] relayOut
);
    import dpl_pkg::*;

    // Current ceiling range 0.1..1.1 x rated
    localparam logic [15:0] CEIL_MIN = 16'((32'(RATED_CURRENT) + 32'h9) / 32'hA);
    localparam logic [15:0] CEIL_MAX = 16'((32'(RATED_CURRENT) * 32'hB) / 32'hA);

    typedef enum logic [1:0] {
        DPL_BUS_IDLE = 2'h0,
        DPL_BUS_RESP = 2'h1
    } dpl_bus_t;

    typedef struct packed {
        logic [2:0] selHiSync, selLoSync, extSync, stopSync;
        logic haveAw, haveW, bValid, rValid, arReady, awRdy, wRdy;
        logic [7:0] wAddr;
        logic [31:0] wData;
        logic [31:0] rData;
        logic [1:0] bResp;
        logic [4:0] ctrl;
        logic [15:0] curCeil, bypBw, curLo, curHi, fLo, fHi;
        logic [31:0] refLo, refHi, refMin, refMax;
        logic [23:0] route;
        logic [31:0] result;
        logic [15:0] fCmd;
        logic off, trip;
        logic [5:0] warn;
        logic [1:0] sig, rly;
    } dpl_state_t;

    dpl_state_t st_reg, st_next;
    logic [15:0] presetRd, bypRd;
    logic [1:0] presetIdx;
    logic [1:0] bypIdx;
    logic presetWr, bypWr;
    logic [7:0] presetOff;

    // Clamp helper for 16-bit limits
    function automatic logic [15:0] dpl_clamp(input logic [15:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Signed scaling by hundredths of a percent
    function automatic logic [31:0] dpl_pct(input logic [31:0] base, input logic [15:0] pct);
        logic signed [63:0] p;
        p = $signed({{32{base[31]}}, base}) * $signed({{48{pct[15]}}, pct});
        return 32'(p / 64'sd10000);
    endfunction

    // Preset select lines from sync stage two; index is code
    assign presetIdx = {st_reg.selHiSync[1], st_reg.selLoSync[1]};
    // Bypass scan index cycles every clock
    logic [1:0] scan_reg;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            scan_reg <= 2'h0;
        end else begin
            scan_reg <= scan_reg + 2'h1;
        end
    end
    assign bypIdx = presetWr || bypWr ? st_reg.wAddr[3:2] : scan_reg;
    // Presets straddle a 16-byte boundary, so decode by range, not by nibble
    assign presetOff = st_reg.wAddr - DPL_A_PRESET0;
    assign presetWr = st_reg.haveAw && st_reg.haveW && !st_reg.bValid &&
        (st_reg.wAddr >= DPL_A_PRESET0) && (st_reg.wAddr < DPL_A_CURR_CEIL);
    assign bypWr = st_reg.haveAw && st_reg.haveW && !st_reg.bValid &&
        (st_reg.wAddr[7:4] == DPL_A_BYP0[7:4]);

    dpl_param_ram #(.DEPTH(DPL_NUM_PRESET), .WIDTH(16), .INIT(16'h0000)) presetRam (
        .clock(clock), .resetn(resetn), .wrEn(presetWr), .wrAddr(presetOff[3:2]),
        .wrData(st_reg.wData[15:0]), .rdAddr(presetIdx), .rdData(presetRd)
    );
    // Bypass frequencies clamped at write to selected range
    dpl_param_ram #(.DEPTH(DPL_NUM_BYPASS), .WIDTH(16), .INIT(DPL_BYP_DEF)) bypRam (
        .clock(clock), .resetn(resetn), .wrEn(bypWr), .wrAddr(st_reg.wAddr[3:2]),
        .wrData(dpl_clamp(st_reg.wData[15:0], 16'h0000,
            st_reg.ctrl[DPL_C_RANGE_BIT] ? DPL_FMAX_HIGH : DPL_FMAX_LOW)),
        .rdAddr(bypIdx), .rdData(bypRd)
    );
    logic [1:0] bypIdxDly;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bypIdxDly <= 2'h0;
        end else begin
            bypIdxDly <= bypIdx;
        end
    end

    // Held skip target from the bypass scan
    logic [15:0] bandLo, bandHi;
    logic inBand;
    logic [DPL_NUM_BYPASS-1:0] bandHit_reg;
    always_comb begin
        bandLo = (bypRd > (st_reg.bypBw >> 1)) ? bypRd - (st_reg.bypBw >> 1) : 16'h0000;
        bandHi = bypRd + (st_reg.bypBw >> 1);
        inBand = (st_reg.bypBw != 16'h0000) && (freqDemand > bandLo)
            && (freqDemand < bandHi);
    end
    logic [15:0] skipTo_reg [DPL_NUM_BYPASS];
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bandHit_reg <= '0;
            for (int i = 0; i < DPL_NUM_BYPASS; i++) begin
                skipTo_reg[i] <= 16'h0000;
            end
        end else begin
            bandHit_reg[bypIdxDly] <= inBand;
            skipTo_reg[bypIdxDly] <= bandLo;
        end
    end

    // Next-state logic for bus, parameters and supervision
    always_comb begin
        logic [31:0] rv;
        logic [31:0] span;
        logic [31:0] res;
        logic [15:0] fc;
        logic armed, wCur, wFreq, wRef;
        logic [7:0] a;
        rv = 32'h0;
        span = st_reg.refMax - st_reg.refMin;
        res = 32'h0;
        fc = freqDemand;
        armed = 1'b0;
        wCur = 1'b0;
        wFreq = 1'b0;
        wRef = 1'b0;
        a = araddr;
        st_next = st_reg;
        st_next.selHiSync = {st_reg.selHiSync[1:0], presetSelHi};
        st_next.selLoSync = {st_reg.selLoSync[1:0], presetSelLo};
        st_next.extSync = {st_reg.extSync[1:0], extPresetSel};
        st_next.stopSync = {st_reg.stopSync[1:0], localKeypadStop};

        // Write channel: address and data in either order
        if (awvalid && !st_reg.haveAw) begin
            st_next.haveAw = 1'b1;
            st_next.wAddr = awaddr;
        end
        if (wvalid && !st_reg.haveW) begin
            st_next.haveW = 1'b1;
            st_next.wData = wdata;
        end
        if (st_reg.haveAw && st_reg.haveW && !st_reg.bValid) begin
            st_next.bValid = 1'b1;
            st_next.bResp = DPL_RESP_OKAY;
            if (wstrb != 4'h0) begin
                if (st_reg.wAddr == DPL_A_CTRL) begin
                    st_next.ctrl = st_reg.wData[4:0];
                end else if (st_reg.wAddr == DPL_A_CURR_CEIL) begin
                    st_next.curCeil = dpl_clamp(st_reg.wData[15:0], CEIL_MIN, CEIL_MAX);
                end else if (st_reg.wAddr == DPL_A_BYP_BW) begin
                    st_next.bypBw = dpl_clamp(st_reg.wData[15:0], 16'h0000, DPL_BW_MAX);
                end else if (st_reg.wAddr == DPL_A_CURR_LO) begin
                    st_next.curLo = dpl_clamp(st_reg.wData[15:0], 16'h0000, st_reg.curHi);
                end else if (st_reg.wAddr == DPL_A_CURR_HI) begin
                    st_next.curHi = dpl_clamp(st_reg.wData[15:0], st_reg.curLo, MAX_CURRENT);
                end else if (st_reg.wAddr == DPL_A_FREQ_LO) begin
                    st_next.fLo = dpl_clamp(st_reg.wData[15:0], 16'h0000, st_reg.fHi);
                end else if (st_reg.wAddr == DPL_A_FREQ_HI) begin
                    st_next.fHi = dpl_clamp(st_reg.wData[15:0], st_reg.fLo,
                        st_reg.ctrl[DPL_C_RANGE_BIT] ? DPL_FMAX_HIGH : DPL_FMAX_LOW);
                end else if (st_reg.wAddr == DPL_A_REF_LO) begin
                    st_next.refLo = st_reg.wData;
                end else if (st_reg.wAddr == DPL_A_REF_HI) begin
                    st_next.refHi = st_reg.wData;
                end else if (st_reg.wAddr == DPL_A_REF_MIN) begin
                    st_next.refMin = st_reg.wData;
                end else if (st_reg.wAddr == DPL_A_REF_MAX) begin
                    st_next.refMax = st_reg.wData;
                end else if (st_reg.wAddr == DPL_A_ROUTE) begin
                    st_next.route = st_reg.wData[23:0];
                end else if (!presetWr && !bypWr) begin
                    st_next.bResp = DPL_RESP_SLVERR;
                end
            end
        end
        if (st_reg.bValid && bready) begin
            st_next.bValid = 1'b0;
            st_next.haveAw = 1'b0;
            st_next.haveW = 1'b0;
        end
        // Ready flags kept as flops so the bus outputs carry no gate
        st_next.awRdy = !st_next.haveAw;
        st_next.wRdy = !st_next.haveW;

        // Read channel, one outstanding read
        st_next.arReady = !st_reg.rValid && !st_reg.arReady;
        if (arvalid && st_reg.arReady) begin
            st_next.rValid = 1'b1;
            if (a == DPL_A_CTRL) begin
                rv = {27'h0, st_reg.ctrl};
            end else if (a == DPL_A_STATUS) begin
                rv = {22'h0, st_reg.off, st_reg.trip, st_reg.sig, st_reg.warn};
            end else if (a == DPL_A_CURR_CEIL) begin
                rv = {16'h0, st_reg.curCeil};
            end else if (a == DPL_A_BYP_BW) begin
                rv = {16'h0, st_reg.bypBw};
            end else if (a == DPL_A_CURR_LO) begin
                rv = {16'h0, st_reg.curLo};
            end else if (a == DPL_A_CURR_HI) begin
                rv = {16'h0, st_reg.curHi};
            end else if (a == DPL_A_FREQ_LO) begin
                rv = {16'h0, st_reg.fLo};
            end else if (a == DPL_A_FREQ_HI) begin
                rv = {16'h0, st_reg.fHi};
            end else if (a == DPL_A_REF_LO) begin
                rv = st_reg.refLo;
            end else if (a == DPL_A_REF_HI) begin
                rv = st_reg.refHi;
            end else if (a == DPL_A_REF_MIN) begin
                rv = st_reg.refMin;
            end else if (a == DPL_A_REF_MAX) begin
                rv = st_reg.refMax;
            end else if (a == DPL_A_ROUTE) begin
                rv = {8'h0, st_reg.route};
            end else if (a == DPL_A_RESULT) begin
                rv = st_reg.result;
            end
            st_next.rData = rv;
        end
        if (st_reg.rValid && rready) begin
            st_next.rValid = 1'b0;
        end

        // Resulting reference; units follow closedLoop upstream (Hz or process)
        case (dpl_reftype_t'(st_reg.ctrl[1:0]))
            DPL_REF_SUM: res = extRefSum + dpl_pct(span, presetRd);
            DPL_REF_RELATIVE: res = extRefSum + dpl_pct(extRefSum, presetRd);
            DPL_REF_EXTPRESET: res = st_reg.extSync[1] ?
                st_reg.refMin + dpl_pct(span, presetRd) : extRefSum;
            default: res = extRefSum;
        endcase
        st_next.result = res;

        // Frequency command jumps below any active band
        for (int i = 0; i < DPL_NUM_BYPASS; i++) begin
            if (bandHit_reg[i]) begin
                fc = skipTo_reg[i];
            end
        end
        st_next.fCmd = fc;

        // Keypad stop during current limit cuts the output
        if (st_reg.stopSync[1] && motorCurrent >= st_reg.curCeil) begin
            st_next.off = 1'b1;
        end else if (stopped) begin
            st_next.off = 1'b0;
        end

        // Supervision is armed only at reference, not ramping or stopped
        armed = !rampingUp && !rampingDown && !stopped && (outputFreq == freqDemand);
        st_next.warn[0] = armed && motorCurrent < st_reg.curLo &&
            st_reg.ctrl[DPL_C_NOLOAD_BIT] == DPL_NOLOAD_WARN;
        st_next.warn[1] = armed && motorCurrent > st_reg.curHi;
        st_next.warn[2] = armed && outputFreq < st_reg.fLo;
        st_next.warn[3] = armed && outputFreq > st_reg.fHi;
        st_next.warn[4] = armed && remoteRefActive &&
            $signed(remoteRef) < $signed(st_reg.refLo);
        st_next.warn[5] = armed && remoteRefActive &&
            $signed(remoteRef) > $signed(st_reg.refHi);
        // Trip is sticky; clear bit in control drops it, trip event wins
        if (st_reg.ctrl[DPL_C_TRIPCLR_BIT]) begin
            st_next.trip = 1'b0;
            st_next.ctrl[DPL_C_TRIPCLR_BIT] = 1'b0;
        end
        if (armed && motorCurrent < st_reg.curLo &&
                st_reg.ctrl[DPL_C_NOLOAD_BIT] == DPL_NOLOAD_TRIP) begin
            st_next.trip = 1'b1;
        end
        // Routing: 6-bit masks per output, OR of selected warnings
        for (int k = 0; k < 2; k++) begin
            st_next.sig[k] = |(st_reg.warn & st_reg.route[6*k +: 6]);
            st_next.rly[k] = |(st_reg.warn & st_reg.route[12+6*k +: 6]);
        end
    end

    // Single state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.curCeil <= CEIL_MAX;
            st_reg.awRdy <= 1'b1;
            st_reg.wRdy <= 1'b1;
            st_reg.curHi <= MAX_CURRENT;
            st_reg.curLo <= DPL_CURR_LO_DEF;
            st_reg.fLo <= DPL_FREQ_LO_DEF;
            st_reg.fHi <= DPL_FREQ_HI_DEF;
            st_reg.refLo <= DPL_REF_LO_DEF;
            st_reg.refHi <= DPL_REF_HI_DEF;
            st_reg.refMin <= DPL_REF_MIN_DEF;
            st_reg.refMax <= DPL_REF_MAX_DEF;
        end else begin
            st_reg <= st_next;
        end
    end

    assign awready = st_reg.awRdy;
    assign wready = st_reg.wRdy;
    assign bvalid = st_reg.bValid;
    assign bresp = st_reg.bResp;
    assign arready = st_reg.arReady;
    assign rvalid = st_reg.rValid;
    assign rdata = st_reg.rData;
    assign rresp = DPL_RESP_OKAY;
    assign resultRef = st_reg.result;
    assign freqCommand = st_reg.fCmd;
    assign currentCeiling = st_reg.curCeil;
    assign outputOff = st_reg.off;
    assign noLoadTrip = st_reg.trip;
    assign warnFlags = st_reg.warn;
    assign signalOut = st_reg.sig;
    assign relayOut = st_reg.rly;

    // Armed mirror for the checks, visible outside the process
    logic armed_chk;
    assign armed_chk = !rampingUp && !rampingDown && !stopped && outputFreq == freqDemand;

    // Checks
    noWarnStopped_a: assert property (@(posedge clock) disable iff (!resetn)
        stopped |=> warnFlags == 6'h0) else $error("warning while stopped");
    refLocal_a: assert property (@(posedge clock) disable iff (!resetn)
        !remoteRefActive |=> !warnFlags[4] && !warnFlags[5]) else $error("ref warn local");
    hiCurr_a: assert property (@(posedge clock) disable iff (!resetn)
        armed_chk && motorCurrent > st_reg.curHi |=> warnFlags[1]) else $error("hi curr");
    loFreq_a: assert property (@(posedge clock) disable iff (!resetn)
        armed_chk && outputFreq < st_reg.fLo |=> warnFlags[2]) else $error("lo freq");
    ceilRange_a: assert property (@(posedge clock) disable iff (!resetn)
        currentCeiling >= CEIL_MIN && currentCeiling <= CEIL_MAX) else $error("ceil range");
    floorBelow_a: assert property (@(posedge clock) disable iff (!resetn)
        st_reg.curLo <= st_reg.curHi) else $error("low over high");
    bwRange_a: assert property (@(posedge clock) disable iff (!resetn)
        st_reg.bypBw <= DPL_BW_MAX) else $error("bandwidth range");
    stopCoast_a: assert property (@(posedge clock) disable iff (!resetn)
        st_reg.stopSync[1] && motorCurrent >= currentCeiling |=> outputOff) else $error("no coast");
endmodule
`default_nettype wire

// ---- core/dpl_pkg.sv ----
package dpl_pkg;
    // Fixed-point formats: frequency 0.1 Hz, current 0.1 A, reference 0.001 units
    localparam int DPL_FREQ_W = 16;
    localparam int DPL_CURR_W = 16;
    localparam int DPL_REF_W = 32;
    localparam int DPL_PCT_W = 16;
    localparam int DPL_NUM_PRESET = 4;
    localparam int DPL_NUM_BYPASS = 4;
    localparam int DPL_ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] DPL_A_CTRL = 8'h00;
    localparam logic [7:0] DPL_A_STATUS = 8'h04;
    localparam logic [7:0] DPL_A_PRESET0 = 8'h08;
    localparam logic [7:0] DPL_A_CURR_CEIL = 8'h18;
    localparam logic [7:0] DPL_A_BYP_BW = 8'h1C;
    localparam logic [7:0] DPL_A_BYP0 = 8'h20;
    localparam logic [7:0] DPL_A_CURR_LO = 8'h30;
    localparam logic [7:0] DPL_A_CURR_HI = 8'h34;
    localparam logic [7:0] DPL_A_FREQ_LO = 8'h38;
    localparam logic [7:0] DPL_A_FREQ_HI = 8'h3C;
    localparam logic [7:0] DPL_A_REF_LO = 8'h40;
    localparam logic [7:0] DPL_A_REF_HI = 8'h44;
    localparam logic [7:0] DPL_A_REF_MIN = 8'h48;
    localparam logic [7:0] DPL_A_REF_MAX = 8'h4C;
    localparam logic [7:0] DPL_A_ROUTE = 8'h50;
    localparam logic [7:0] DPL_A_RESULT = 8'h54;

    // Control register fields
    localparam int DPL_C_REFTYPE_LSB = 0;
    localparam int DPL_C_NOLOAD_BIT = 2;
    localparam int DPL_C_RANGE_BIT = 3;
    localparam int DPL_C_TRIPCLR_BIT = 4;

    // Reference type codes
    typedef enum logic [1:0] {
        DPL_REF_SUM = 2'h0,
        DPL_REF_RELATIVE = 2'h1,
        DPL_REF_EXTPRESET = 2'h2
    } dpl_reftype_t;
    localparam logic DPL_NOLOAD_TRIP = 1'h0;
    localparam logic DPL_NOLOAD_WARN = 1'h1;

    // Ranges and factory values
    localparam logic [15:0] DPL_BW_MAX = 16'h03E8;          // 100.0 Hz
    localparam logic [15:0] DPL_FMAX_LOW = 16'h04B0;        // 120.0 Hz
    localparam logic [15:0] DPL_FMAX_HIGH = 16'h2710;       // 1000.0 Hz
    localparam logic [15:0] DPL_BYP_DEF = 16'h04B0;         // 120.0 Hz
    localparam logic [15:0] DPL_FREQ_LO_DEF = 16'h0000;     // 0.0 Hz
    localparam logic [15:0] DPL_FREQ_HI_DEF = 16'h04B0;     // 120.0 Hz
    localparam logic [15:0] DPL_CURR_LO_DEF = 16'h0000;     // 0.0 A
    localparam logic [31:0] DPL_REF_LO_DEF = 32'hC4653601;  // -999999.999
    localparam logic [31:0] DPL_REF_HI_DEF = 32'h3B9AC9FF;  // 999999.999
    localparam logic [31:0] DPL_REF_MIN_DEF = 32'h00000000;
    localparam logic [31:0] DPL_REF_MAX_DEF = 32'h0000C350; // 50.000 Hz
    localparam logic [15:0] DPL_PCT_FULL = 16'h2710;        // 100.00 %
    localparam logic [1:0] DPL_RESP_OKAY = 2'h0;
    localparam logic [1:0] DPL_RESP_SLVERR = 2'h2;
endpackage

// ---- core/dpl_param_ram.sv ----
`timescale 1ns/10ps
`default_nettype none
// Small parameter store, registered read port
module dpl_param_ram #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 16,
    parameter logic [15:0] INIT = 16'h0000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Write port
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Reset loads factory value so defaults hold
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= WIDTH'(INIT);
            end
            rdData <= WIDTH'(INIT);
        end else begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule
`default_nettype wire

// ---- test/dpl_drive_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Power stage: output frequency follows the command one edge later
module dpl_drive_model
    import dpl_pkg::*;
(
    // Clock
    input wire logic clock,
    // From the monitor
    input wire logic [dpl_pkg::DPL_FREQ_W-1:0] freqCommand,
    input wire logic outputOff,
    // To the monitor
    output logic [dpl_pkg::DPL_FREQ_W-1:0] outputFreq
);
    // Coasting drops the frequency at once, no ramp modelled
    always_ff @(posedge clock) begin
        outputFreq <= outputOff ? 16'h0000 : freqCommand;
    end
endmodule
`default_nettype wire

// ---- test/tb_drive_preset_limit_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_drive_preset_limit_monitor;
    import dpl_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic outputOff, noLoadTrip, remoteRefActive = 1'b0, stopped = 1'b0;
    logic presetSelHi = 1'b0, presetSelLo = 1'b1, localKeypadStop = 1'b0;
    logic [15:0] freqDemand = 16'h01F4;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, resultRef, rd, remoteRef = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, signalOut, relayOut, wrsp;
    logic [15:0] motorCurrent = 16'h0030, outputFreq, freqCommand, currentCeiling;
    logic [5:0] warnFlags;
    int nMismatch = 0, checksDone = 0;
    // Clock and reset
    initial begin
        forever #50 clock = ~clock;
    end
    dpl_monitor DUT (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .presetSelHi(presetSelHi), .presetSelLo(presetSelLo), .extPresetSel(1'b0),
        .localKeypadStop(localKeypadStop),
        .remoteRefActive(remoteRefActive), .closedLoop(1'b0), .rampingUp(1'b0),
        .rampingDown(1'b0), .stopped(stopped), .motorCurrent(motorCurrent),
        .outputFreq(outputFreq), .freqDemand(freqDemand), .extRefSum(32'h00000000),
        .remoteRef(remoteRef), .resultRef(resultRef), .freqCommand(freqCommand),
        .currentCeiling(currentCeiling), .outputOff(outputOff), .noLoadTrip(noLoadTrip),
        .warnFlags(warnFlags), .signalOut(signalOut), .relayOut(relayOut));
    dpl_drive_model partner (.clock(clock), .freqCommand(freqCommand), .outputOff(outputOff),
        .outputFreq(outputFreq));
    task automatic summarize();
        $display("mismatches %0d, checks %0d", nMismatch, checksDone);
        if (nMismatch == 0 && checksDone > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles hold each channel until its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                wrsp = bresp;
                break;
            end
        end
        bready <= 1'b0;
        @(posedge clock);
        if (n == 50) begin nMismatch++; summarize(); end
    endtask
    task automatic rdw(input logic [7:0] a);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rready <= 1'b0;
        @(posedge clock);
        if (n == 50) begin nMismatch++; summarize(); end
    endtask
    // Bypass scan and preset path need up to six edges; margin added
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        settle();
        chk({16'h0000, currentCeiling}, 32'h0000006E);
        wr(DPL_A_PRESET0 + 8'h04, 32'h00001388); settle();
        chk(resultRef, 32'h000061A8);
        rdw(DPL_A_RESULT); chk(rd, 32'h000061A8);
        presetSelHi <= 1'b1; presetSelLo <= 1'b0; settle();
        chk(resultRef, 32'h00000000);
        rdw(DPL_A_FREQ_LO); chk(rd, 32'h00000000);
        wr(DPL_A_CURR_CEIL, 32'h00000000); settle();
        chk({16'h0000, currentCeiling}, 32'h0000000A);
        chk({30'h0, wrsp}, {30'h0, DPL_RESP_OKAY});
        wr(DPL_A_ROUTE, 32'h00008008); wr(DPL_A_FREQ_HI, 32'h00000190); settle();
        chk({26'h0, warnFlags}, 32'h00000008);
        chk({31'h0, signalOut[0]}, 32'h00000001);
        chk({31'h0, relayOut[0]}, 32'h00000001);
        stopped <= 1'b1; settle();
        chk({26'h0, warnFlags}, 32'h00000000);
        stopped <= 1'b0; motorCurrent <= 16'h000A;
        wr(DPL_A_FREQ_HI, 32'h000004B0); wr(DPL_A_CTRL, 32'h00000004);
        wr(DPL_A_CURR_LO, 32'h00000014); settle();
        chk({26'h0, warnFlags}, 32'h00000001);
        chk({31'h0, noLoadTrip}, 32'h00000000);
        wr(DPL_A_CTRL, 32'h00000000); settle();
        chk({31'h0, noLoadTrip}, 32'h00000001);
        motorCurrent <= 16'h0064; wr(DPL_A_CURR_HI, 32'h00000050); settle();
        chk({26'h0, warnFlags}, 32'h00000002);
        // Negative remote reference below a zero floor
        motorCurrent <= 16'h0030; remoteRef <= 32'hFFFFFFFF; remoteRefActive <= 1'b1;
        wr(DPL_A_REF_LO, 32'h00000000); settle();
        chk({26'h0, warnFlags}, 32'h00000010);
        remoteRefActive <= 1'b0; settle();
        chk({26'h0, warnFlags}, 32'h00000000);
        wr(DPL_A_BYP_BW, 32'h00000064); wr(DPL_A_BYP0, 32'h000001F4); settle();
        chk({16'h0000, freqCommand}, 32'h000001C2);
        // Demand inside the band of a factory-default bypass point
        freqDemand <= 16'h04B0; settle();
        chk({16'h0000, freqCommand}, 32'h0000047E);
        localKeypadStop <= 1'b1; settle();
        chk({31'h0, outputOff}, 32'h00000001);
        localKeypadStop <= 1'b0; stopped <= 1'b1; settle();
        chk({31'h0, outputOff}, 32'h00000000);
        summarize();
    end
endmodule
`default_nettype wire
